// ==== logic/aic_defines.svh ====
// constants for the two-wire converter front end and its bus master
// assumes a 125 MHz system clock on both ends
`ifndef AIC_DEFINES_SVH
`define AIC_DEFINES_SVH

// system clock period and serial clock period, in ns
`define AIC_CLK_PERIOD_NS 8
`define AIC_SCL_PERIOD_NS 10000
// quarter of a serial clock period in system clocks
`define AIC_SCL_QTR_CYC ((`AIC_SCL_PERIOD_NS / `AIC_CLK_PERIOD_NS) / 4)

// device code in the top four address bits; value is arbitrary
`define AIC_DEV_CODE 4'h6
// default chip-select address bits
`define AIC_CS_DEFAULT 3'h5
// direction bit values
`define AIC_DIR_READ 1'b1
`define AIC_DIR_WRITE 1'b0

// address byte fields
`define AIC_ADDR_CODE_MSB 7
`define AIC_ADDR_CODE_LSB 4
`define AIC_ADDR_CS_MSB 3
`define AIC_ADDR_CS_LSB 1
`define AIC_ADDR_DIR_BIT 0

// bit counts and the pad sent ahead of the upper result bits
`define AIC_BYTE_BITS 4'h8
`define AIC_LAST_BIT 4'h7
`define AIC_RESULT_PAD 4'h0

`endif

// ==== logic/aic_pkg.sv ====
// types shared by the converter front end and its bus master
// assumes aic_defines.svh is on the include path
`include "aic_defines.svh"

package aic_pkg;

    typedef enum logic [2:0] {
        DEV_IDLE,
        DEV_ADDR,
        DEV_ADDR_ACK,
        DEV_SEND,
        DEV_HOST_ACK,
        DEV_IGNORE
    } aic_dev_state_e;

    typedef enum logic [2:0] {
        MST_IDLE,
        MST_START,
        MST_BIT,
        MST_WAIT,
        MST_STOP
    } aic_mst_state_e;

    typedef enum logic [1:0] {
        FRAME_ADDR,
        FRAME_HIGH,
        FRAME_LOW
    } aic_frame_e;

    typedef struct packed {
        logic scl_meta;
        logic scl_sync;
        logic scl_prev;
        logic sda_meta;
        logic sda_sync;
        logic sda_prev;
        aic_dev_state_e state;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] low_byte;
        logic dir_read;
        logic high_phase;
        logic host_acked;
        logic sda_oe_n;
        logic drive_zero;
        logic conv_start;
        logic selected;
    } aic_dev_s;

    typedef struct packed {
        aic_mst_state_e state;
        aic_frame_e frame;
        logic [1:0] phase;
        logic [15:0] div;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [3:0] high_bits;
        logic ack_bit;
        logic dir_read;
        logic [7:0] words;
        logic sda_meta;
        logic sda_sync;
        logic scl_oe_n;
        logic sda_oe_n;
        logic drive_zero;
        logic [11:0] slot0;
        logic [11:0] slot1;
        logic slot0_valid;
        logic slot1_valid;
        logic cmd_ready;
        logic busy;
        logic nack_seen;
        logic done;
    } aic_mst_s;

endpackage : aic_pkg

// ==== logic/aic_link_if.sv ====
// two-wire link between the bus master and the converter front end
// open-drain wires: a line is low when any enabled driver pulls it
`timescale 1ns/1ps
`default_nettype none

interface aic_link_if;
    logic scl_o;
    logic scl_oe_n;
    logic mst_sda_o;
    logic mst_sda_oe_n;
    logic dev_sda_o;
    logic dev_sda_oe_n;
    logic scl;
    logic sda;

    // pull-ups win unless a driver is enabled and pulls low
    assign scl = scl_oe_n | scl_o;
    assign sda = (mst_sda_oe_n | mst_sda_o) & (dev_sda_oe_n | dev_sda_o);

    modport master (
        output scl_o,
        output scl_oe_n,
        output mst_sda_o,
        output mst_sda_oe_n,
        input scl,
        input sda
    );

    modport device (
        output dev_sda_o,
        output dev_sda_oe_n,
        input scl,
        input sda
    );
endinterface : aic_link_if

`default_nettype wire

// ==== logic/aic_device.sv ====
// converter-side slave end of the two-wire link
// assumes the master owns the clock line and the converter core keeps
// conv_result valid from conv_start until the result is loaded
//
// Summary of operation
// - sda falling while scl high is start
// - sda rising while scl high is stop
// - master starts only on an idle bus
// - data changes only while clock is low
// - one clock pulse per data bit
// - master sets byte count, no limit here
// - receiver acknowledges each byte on ninth clock
// - acknowledge holds data low through clock high
// - not-acknowledge on a read releases the line
// - only the master drives the clock
// - first byte after start is the address
// - top four bits must match device code
// - three chip-select bits must match configuration
// - eighth address bit: one read, zero write
// - read request triggers a conversion
// - write address is acknowledged, then released
// - conversion starts on falling edge after direction
// - send pad, upper nibble, then lower byte
// - end of low byte repeats conversion, acknowledged or not
// - result goes out msb first, straight binary
`timescale 1ns/1ps
`default_nettype none
`include "aic_defines.svh"

module aic_device
    import aic_pkg::*;
#(
    parameter logic [3:0] DEV_CODE = `AIC_DEV_CODE,
    parameter logic CHIP_SELECT_BIT_HIGH = 1'(`AIC_CS_DEFAULT >> 2),
    parameter logic CHIP_SELECT_BIT_MID = 1'(`AIC_CS_DEFAULT >> 1),
    parameter logic CHIP_SELECT_BIT_LOW = 1'(`AIC_CS_DEFAULT)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    aic_link_if.device link,
    // converter core
    input wire logic [11:0] conv_result,
    output logic conv_start,
    output logic selected
);

    aic_dev_s q;
    aic_dev_s n;

    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic [2:0] cs_cfg;

    assign cs_cfg = {CHIP_SELECT_BIT_HIGH, CHIP_SELECT_BIT_MID,
                     CHIP_SELECT_BIT_LOW};

    // true when the address byte names this device
    function automatic logic addr_match(input logic [7:0] a,
                                        input logic [3:0] code,
                                        input logic [2:0] cs);
        addr_match = (a[`AIC_ADDR_CODE_MSB:`AIC_ADDR_CODE_LSB] == code)
                  && (a[`AIC_ADDR_CS_MSB:`AIC_ADDR_CS_LSB] == cs);
    endfunction : addr_match

    // edges are taken from the synchronised copies only, so the first
    // stage of each synchroniser feeds nothing but the second
    assign scl_rise = q.scl_sync & ~q.scl_prev;
    assign scl_fall = ~q.scl_sync & q.scl_prev;
    assign start_seen = q.scl_sync & q.scl_prev
                      & q.sda_prev & ~q.sda_sync;
    assign stop_seen = q.scl_sync & q.scl_prev
                     & ~q.sda_prev & q.sda_sync;

    always_comb begin
        n = q;
        n.scl_meta = link.scl;
        n.scl_sync = q.scl_meta;
        n.scl_prev = q.scl_sync;
        n.sda_meta = link.sda;
        n.sda_sync = q.sda_meta;
        n.sda_prev = q.sda_sync;
        n.conv_start = 1'b0;
        n.drive_zero = 1'b0;
        if (start_seen) begin
            // a start aborts anything, including a transfer in flight
            n.state = DEV_ADDR;
            n.bit_cnt = 4'h0;
            n.sda_oe_n = 1'b1;
            n.selected = 1'b0;
        end else if (stop_seen) begin
            n.state = DEV_IDLE;
            n.sda_oe_n = 1'b1;
            n.selected = 1'b0;
        end else begin
            case (q.state)
                DEV_IDLE: begin
                    n.sda_oe_n = 1'b1;
                end
                DEV_ADDR: begin
                    // bits are sampled while the clock is high
                    if (scl_rise) begin
                        n.shift = {q.shift[6:0], q.sda_sync};
                        n.bit_cnt = q.bit_cnt + 4'h1;
                    end else if (scl_fall
                                 && q.bit_cnt == `AIC_BYTE_BITS) begin
                        if (addr_match(q.shift, DEV_CODE, cs_cfg)) begin
                            n.sda_oe_n = 1'b0;
                            n.state = DEV_ADDR_ACK;
                            n.selected = 1'b1;
                            n.dir_read = q.shift[`AIC_ADDR_DIR_BIT]
                                       == `AIC_DIR_READ;
                            // sampling begins at the end of the rw bit
                            n.conv_start = n.dir_read;
                        end else begin
                            n.state = DEV_IGNORE;
                        end
                    end
                end
                DEV_ADDR_ACK: begin
                    // acknowledge stays low until the ninth clock falls
                    if (scl_fall) begin
                        n.bit_cnt = 4'h0;
                        if (q.dir_read) begin
                            n.shift = {`AIC_RESULT_PAD,
                                       conv_result[11:8]};
                            n.low_byte = conv_result[7:0];
                            n.high_phase = 1'b1;
                            n.sda_oe_n = n.shift[7];
                            n.state = DEV_SEND;
                        end else begin
                            n.sda_oe_n = 1'b1;
                            n.state = DEV_IGNORE;
                        end
                    end
                end
                DEV_SEND: begin
                    // data is changed only after the clock has fallen
                    if (scl_fall) begin
                        if (q.bit_cnt == `AIC_LAST_BIT) begin
                            n.sda_oe_n = 1'b1;
                            n.state = DEV_HOST_ACK;
                            // next sample starts at the end of the lsb
                            n.conv_start = ~q.high_phase;
                        end else begin
                            n.shift = {q.shift[6:0], 1'b0};
                            n.sda_oe_n = n.shift[7];
                            n.bit_cnt = q.bit_cnt + 4'h1;
                        end
                    end
                end
                DEV_HOST_ACK: begin
                    if (scl_rise) begin
                        n.host_acked = ~q.sda_sync;
                    end else if (scl_fall) begin
                        n.bit_cnt = 4'h0;
                        if (!q.host_acked) begin
                            n.sda_oe_n = 1'b1;
                            n.selected = 1'b0;
                            n.state = DEV_IGNORE;
                        end else if (q.high_phase) begin
                            n.shift = q.low_byte;
                            n.high_phase = 1'b0;
                            n.sda_oe_n = n.shift[7];
                            n.state = DEV_SEND;
                        end else begin
                            // continuous mode: fresh result, same framing
                            n.shift = {`AIC_RESULT_PAD,
                                       conv_result[11:8]};
                            n.low_byte = conv_result[7:0];
                            n.high_phase = 1'b1;
                            n.sda_oe_n = n.shift[7];
                            n.state = DEV_SEND;
                        end
                    end
                end
                DEV_IGNORE: begin
                    // no byte limit or timeout: only start or stop leaves
                    n.sda_oe_n = 1'b1;
                end
                default: begin
                    n.state = DEV_IDLE;
                    n.sda_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.scl_meta <= 1'b1;
            q.scl_sync <= 1'b1;
            q.scl_prev <= 1'b1;
            q.sda_meta <= 1'b1;
            q.sda_sync <= 1'b1;
            q.sda_prev <= 1'b1;
            q.sda_oe_n <= 1'b1;
            q.state <= DEV_IDLE;
        end else begin
            q <= n;
        end
    end

    // the clock line has no driver on this end at all
    assign link.dev_sda_o = q.drive_zero;
    assign link.dev_sda_oe_n = q.sda_oe_n;
    assign conv_start = q.conv_start;
    assign selected = q.selected;

endmodule : aic_device

`default_nettype wire

// ==== logic/aic_master.sv ====
// bus-master end of the two-wire link, with a two-entry result buffer
// assumes a single master and no clock stretching by the slave
`timescale 1ns/1ps
`default_nettype none
`include "aic_defines.svh"

module aic_master
    import aic_pkg::*;
#(
    parameter logic [3:0] DEV_CODE = `AIC_DEV_CODE,
    parameter logic [15:0] QTR_CYC = 16'(`AIC_SCL_QTR_CYC)
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    aic_link_if.master link,
    // command
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic [2:0] cmd_cs,
    input wire logic cmd_read,
    input wire logic [7:0] cmd_words,
    // results
    output logic res_valid,
    input wire logic res_ready,
    output logic [11:0] res_data,
    // status
    output logic busy,
    output logic nack_seen,
    output logic done
);

    aic_mst_s q;
    aic_mst_s n;
    logic tick;

    assign tick = (q.div == 16'h0000);

    always_comb begin
        n = q;
        n.sda_meta = link.sda;
        n.sda_sync = q.sda_meta;
        n.done = 1'b0;
        n.drive_zero = 1'b0;
        if (q.state != MST_IDLE) begin
            n.div = tick ? QTR_CYC - 16'h0001 : q.div - 16'h0001;
        end
        // drain the buffer head first so a push can reuse the slot
        if (q.slot0_valid && res_ready) begin
            n.slot0 = q.slot1;
            n.slot0_valid = q.slot1_valid;
            n.slot1_valid = 1'b0;
        end
        case (q.state)
            MST_IDLE: begin
                n.cmd_ready = 1'b1;
                n.busy = 1'b0;
                if (q.cmd_ready && cmd_valid) begin
                    n.cmd_ready = 1'b0;
                    n.busy = 1'b1;
                    n.nack_seen = 1'b0;
                    n.shift = {DEV_CODE, cmd_cs, cmd_read};
                    n.dir_read = cmd_read;
                    n.words = (cmd_words == 8'h00) ? 8'h01 : cmd_words;
                    n.phase = 2'h0;
                    n.div = QTR_CYC - 16'h0001;
                    n.state = MST_START;
                end
            end
            MST_START: begin
                if (tick) begin
                    n.phase = q.phase + 2'h1;
                    if (q.phase == 2'h0) begin
                        n.sda_oe_n = 1'b0;
                    end else begin
                        n.scl_oe_n = 1'b0;
                        n.frame = FRAME_ADDR;
                        n.bit_cnt = 4'h0;
                        n.phase = 2'h0;
                        n.state = MST_BIT;
                    end
                end
            end
            MST_BIT: begin
                if (tick) begin
                    n.phase = q.phase + 2'h1;
                    case (q.phase)
                        2'h0: begin
                            // change data mid-way through the low phase
                            if (q.bit_cnt == `AIC_BYTE_BITS) begin
                                n.sda_oe_n = (q.frame == FRAME_ADDR)
                                    || (q.frame == FRAME_LOW
                                        && q.words == 8'h01);
                            end else begin
                                n.sda_oe_n = (q.frame != FRAME_ADDR)
                                    || q.shift[7];
                            end
                        end
                        2'h1: begin
                            n.scl_oe_n = 1'b1;
                        end
                        2'h2: begin
                            if (q.bit_cnt == `AIC_BYTE_BITS) begin
                                n.ack_bit = q.sda_sync;
                            end else begin
                                n.shift = {q.shift[6:0], q.sda_sync};
                            end
                        end
                        default: begin
                            n.scl_oe_n = 1'b0;
                            n.bit_cnt = q.bit_cnt + 4'h1;
                            if (q.bit_cnt == `AIC_BYTE_BITS) begin
                                n.bit_cnt = 4'h0;
                                case (q.frame)
                                    FRAME_ADDR: begin
                                        n.nack_seen = q.ack_bit;
                                        n.frame = FRAME_HIGH;
                                        n.state = (q.ack_bit || !q.dir_read)
                                                ? MST_STOP : MST_WAIT;
                                    end
                                    FRAME_HIGH: begin
                                        n.high_bits = q.shift[3:0];
                                        n.frame = FRAME_LOW;
                                    end
                                    default: begin
                                        if (!n.slot0_valid) begin
                                            n.slot0 = {q.high_bits, q.shift};
                                            n.slot0_valid = 1'b1;
                                        end else begin
                                            n.slot1 = {q.high_bits, q.shift};
                                            n.slot1_valid = 1'b1;
                                        end
                                        n.words = q.words - 8'h01;
                                        n.frame = FRAME_HIGH;
                                        n.state = (q.words == 8'h01)
                                                ? MST_STOP : MST_WAIT;
                                    end
                                endcase
                            end
                        end
                    endcase
                end
            end
            MST_WAIT: begin
                // clock held low until a slot is sure to be free
                if (!n.slot1_valid) begin
                    n.phase = 2'h0;
                    n.div = QTR_CYC - 16'h0001;
                    n.state = MST_BIT;
                end
            end
            MST_STOP: begin
                if (tick) begin
                    n.phase = q.phase + 2'h1;
                    case (q.phase)
                        2'h0: n.sda_oe_n = 1'b0;
                        2'h1: n.scl_oe_n = 1'b1;
                        2'h2: n.sda_oe_n = 1'b1;
                        default: begin
                            n.done = 1'b1;
                            n.state = MST_IDLE;
                        end
                    endcase
                end
            end
            default: begin
                n.state = MST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
            q.state <= MST_IDLE;
            q.frame <= FRAME_ADDR;
            q.sda_meta <= 1'b1;
            q.sda_sync <= 1'b1;
            q.scl_oe_n <= 1'b1;
            q.sda_oe_n <= 1'b1;
        end else begin
            q <= n;
        end
    end

    assign link.scl_o = q.drive_zero;
    assign link.scl_oe_n = q.scl_oe_n;
    assign link.mst_sda_o = q.drive_zero;
    assign link.mst_sda_oe_n = q.sda_oe_n;
    assign cmd_ready = q.cmd_ready;
    assign res_valid = q.slot0_valid;
    assign res_data = q.slot0;
    assign busy = q.busy;
    assign nack_seen = q.nack_seen;
    assign done = q.done;

endmodule : aic_master

`default_nettype wire

// ==== test/aic_link_asserts.sv ====
// checker for the two-wire link between bus master and converter end
// assumes the plain link signals and a single clock domain
`timescale 1ns/1ps
`default_nettype none
`include "aic_defines.svh"

module aic_link_asserts #(
    parameter logic [3:0] DEV_CODE = `AIC_DEV_CODE,
    parameter logic [2:0] CS = `AIC_CS_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // link
    input wire logic scl,
    input wire logic sda,
    input wire logic mst_sda_oe_n,
    input wire logic dev_sda_oe_n
);
    logic scl_q;
    logic sda_q;
    logic [7:0] rises_q;
    logic [7:0] addr_q;
    wire logic rise = scl & ~scl_q;
    wire logic start = scl & scl_q & sda_q & ~sda;
    wire logic stop = scl & scl_q & ~sda_q & sda;
    wire logic hit = addr_q[7:1] == {DEV_CODE, CS};
    wire logic ack_slot = rise && rises_q >= 8'h11 && rises_q % 9 == 8;

    // rises counts clock pulses since the last start
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rises_q <= 8'h00;
            addr_q <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start) begin
                rises_q <= 8'h00;
            end else if (rise && rises_q != 8'hFF) begin
                rises_q <= rises_q + 8'h01;
            end
            if (rise && rises_q < 8'h08) begin
                addr_q <= {addr_q[6:0], sda};
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_ack_edge;
        rise && !dev_sda_oe_n;
    endsequence
    sequence s_quiet;
        dev_sda_oe_n [*8] ##1 dev_sda_oe_n [*8];
    endsequence

    AST_DEV_EDGE: assert property ($changed(dev_sda_oe_n) |-> !scl)
        else $error("device data changed while clock high");
    AST_HOLD_LOW: assert property (s_ack_edge |=> !dev_sda_oe_n [*6])
        else $error("device low level not held through clock high");
    AST_START_SRC: assert property (start |-> !mst_sda_oe_n)
        else $error("start not made by the master");
    AST_NINE_BITS: assert property (stop |-> rises_q % 9 == 1)
        else $error("frame clock count not whole bytes");
    AST_ADDR_QUIET: assert property (rises_q < 8'h08 |-> dev_sda_oe_n)
        else $error("device drove during address byte");
    AST_ADDR_ACK: assert property (rise && rises_q == 8'h08 |->
        (sda == 1'b0) == hit)
        else $error("address acknowledge wrong");
    AST_WRITE_REL: assert property (rise && rises_q >= 8'h09 && hit &&
        !addr_q[0] |-> dev_sda_oe_n)
        else $error("device held line after write address");
    AST_MISS_IDLE: assert property (!hit && rises_q >= 8'h08 |->
        dev_sda_oe_n)
        else $error("device drove after foreign address");
    AST_HOST_SLOT: assert property (ack_slot |-> dev_sda_oe_n)
        else $error("device drove in master acknowledge slot");
    AST_NACK_REL: assert property (ack_slot && sda |=> s_quiet)
        else $error("device did not release after not-acknowledge");
endmodule : aic_link_asserts

`default_nettype wire

// ==== test/tb.sv ====
// bench: master and converter end joined over the link
// assumes a 125 MHz clock and a shortened serial clock period
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin \
    total_checks++; \
    if ((g) !== (e)) begin \
        n_errors++; \
        $display("MISMATCH %s exp %0h got %0h", nm, e, g); \
    end \
end

module tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic [2:0] cmd_cs = 3'h0;
    logic cmd_read = 1'b0;
    logic [7:0] cmd_words = 8'h00;
    logic res_ready = 1'b1;
    logic [11:0] conv_result = 12'h0F3;
    logic cmd_ready, res_valid, busy, nack_seen, done, conv_start, selected;
    logic [11:0] res_data;
    logic [11:0] exp_w;
    logic [11:0] exp_q[$];
    int n_errors = 0;
    int total_checks = 0;
    int n_res = 0;
    int n_conv = 0;
    int sel_cyc = 0;

    always #4 clk = ~clk;

    aic_link_if lnk();
    aic_master #(.QTR_CYC(16'h0004)) i_aic_master (
        .clk(clk), .rst(rst), .link(lnk), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_cs(cmd_cs), .cmd_read(cmd_read),
        .cmd_words(cmd_words), .res_valid(res_valid),
        .res_ready(res_ready), .res_data(res_data), .busy(busy),
        .nack_seen(nack_seen), .done(done));
    aic_device i_aic_device (
        .clk(clk), .rst(rst), .link(lnk), .conv_result(conv_result),
        .conv_start(conv_start), .selected(selected));
    aic_link_asserts #(.CS(3'h5)) i_aic_link_asserts (
        .clk(clk), .rst(rst), .scl(lnk.scl), .sda(lnk.sda),
        .mst_sda_oe_n(lnk.mst_sda_oe_n),
        .dev_sda_oe_n(lnk.dev_sda_oe_n));

    // converter core: a fresh sample per start, held until the next
    always @(posedge clk) begin
        if (conv_start === 1'b1) begin
            conv_result <= conv_result + 12'h5A7;
            exp_q.push_back(conv_result + 12'h5A7);
            n_conv++;
        end
        if (res_valid === 1'b1 && res_ready === 1'b1) begin
            n_res++;
            exp_w = exp_q.pop_front();
            `CHK("res_data", exp_w, res_data)
        end
        if (selected === 1'b1) begin
            sel_cyc++;
        end
    end

    task automatic end_of_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    // one bus transaction; stall holds the result side off that long
    task automatic run(input logic [2:0] cs, input logic rd,
                       input logic [7:0] nw, input int stall);
        logic m;
        logic rdm;
        logic [7:0] nwe;
        int i;
        m = cs == 3'h5;
        rdm = m && rd;
        // a zero word count is read as one word
        nwe = (nw == 8'h00) ? 8'h01 : nw;
        n_res = 0;
        n_conv = 0;
        sel_cyc = 0;
        exp_q.delete();
        @(posedge clk);
        `CHK("bus_idle", 1'b1, lnk.scl & lnk.sda)
        cmd_cs <= cs;
        cmd_read <= rd;
        cmd_words <= nw;
        cmd_valid <= 1'b1;
        res_ready <= (stall == 0);
        do @(posedge clk); while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        for (i = 0; i < stall; i++) @(posedge clk);
        if (stall != 0) begin
            `CHK("stalled_words", 0, n_res)
            `CHK("stall_valid", 1'b1, res_valid)
            `CHK("stall_busy", 1'b1, busy)
            res_ready <= 1'b1;
        end
        i = 0;
        while (done !== 1'b1 && i < 20000) begin
            @(posedge clk);
            i++;
        end
        `CHK("done", 1'b1, done)
        `CHK("nack_seen", !m, nack_seen)
        `CHK("words", rdm ? nwe : 8'h00, 8'(n_res))
        `CHK("conversions", rdm ? nwe + 8'h01 : 8'h00, 8'(n_conv))
        `CHK("selected", m, sel_cyc != 0)
        `CHK("drained", 1'b0, res_valid)
    endtask : run

    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        run(3'h5, 1'b1, 8'h01, 0);
        run(3'h5, 1'b1, 8'h03, 0);
        run(3'h5, 1'b0, 8'h01, 0);
        for (int c = 0; c < 8; c++) run(3'(c), 1'b1, 8'h00, 0);
        run(3'h5, 1'b1, 8'h04, 3000);
        end_of_test();
    end

    // about seven times the expected length of the run
    initial begin
        #400000;
        n_errors++;
        end_of_test();
    end
endmodule : tb

`default_nettype wire
